// file: src/ssp_defines.svh
// Behaviour
// - Eight bits in: copy to buffer, set flags
// - Shift most significant bit first, full duplex
// - Buffer write also loads the shift register
// - Write while busy dropped, collision flag set
// - Buffer read clears the buffer full flag
// - Slave overrun sets overflow, new byte lost
// - Master never sets the overflow flag
// - Master sample phase: end or middle
// - Edge select picks the output change edge
// - Polarity bit sets the clock idle level
// - Enable hands the pins to the port
// - Modes 0-2: master at divide 4/16/64
// - Mode 3: master clock is timer half
// - Modes 4/5: slave with/without select control
// - Other mode codes do no serial work
// - Stop bit cleared while port disabled
// - Status: top two bits writable, rest read-only
// - Shift register reached only through buffer
// - Clock pin output in master, input slave
// - Receive is double buffered
// - Master transfer starts on buffer write
// - Port reset forces bit counter to zero
// - Data out driven in master, in mode 5, and in mode 4 only while select low
`ifndef SSP_DEFINES_SVH
`define SSP_DEFINES_SVH

// Register word offsets, byte addresses
`define SSP_OFS_STATUS 5'h00
`define SSP_OFS_CTRL1 5'h04
`define SSP_OFS_BUFFER 5'h08
`define SSP_OFS_IRQ 5'h0c

// Status field positions
`define SSP_ST_SMP 7
`define SSP_ST_CKE 6
`define SSP_ST_STOP 4
`define SSP_ST_BF 0

// Control one field positions
`define SSP_C1_WRITE_COLLISION_FLAG 7
`define SSP_C1_OV 6
`define SSP_C1_EN 5
`define SSP_C1_CKP 4

// Reset values
`define SSP_STATUS_RST 8'h00
`define SSP_CTRL1_RST 8'h00

// Mode select codes
`define SSP_MODE_DIV4 4'h0
`define SSP_MODE_DIV16 4'h1
`define SSP_MODE_DIV64 4'h2
`define SSP_MODE_TMR 4'h3
`define SSP_MODE_SLV_SS 4'h4
`define SSP_MODE_SLV 4'h5

// Half serial clock periods in core clocks
`define SSP_HALF_DIV4 6'h02
`define SSP_HALF_DIV16 6'h08
`define SSP_HALF_DIV64 6'h20

// Half steps of one master byte plus a closing step
`define SSP_LAST_STEP 5'h10

`endif

// file: src/ssp_pkg.sv
package ssp_pkg;

    // Master sequencer states, one-hot
    typedef enum logic [1:0] {
        SSP_M_IDLE = 2'b01,
        SSP_M_RUN = 2'b10
    } ssp_mstate_type;

endpackage

// file: src/ssp_spi.sv
`timescale 1ns/1ps
`default_nettype none
`include "ssp_defines.svh"

module ssp_spi
    import ssp_pkg::*;
#(
    parameter int ADDR_W = 5
) (
    input wire logic ref_clk,
    input wire logic rst,
    // Avalon-MM slave
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Timer two output pulse, same clock
    input wire logic timer_two_tick,
    // Serial pins
    input wire logic sck_in,
    output logic sck_out,
    output logic sck_oe,
    input wire logic serial_in_pin,
    output logic serial_out_pin,
    output logic serial_out_oe,
    input wire logic ss_n_in,
    // High while the port owns its pins
    output logic pins_to_port,
    // Transfer done level
    output logic transfer_done_irq_flag
);

    // Synchronisers for pins
    logic sck_s1_q, sck_s2_q, sck_s3_q;
    logic sdi_s1_q, sdi_s2_q;
    logic ss_s1_q, ss_s2_q;

    // Software visible state
    logic smp_q, smp_d;
    logic cke_q, cke_d;
    logic bf_q, bf_d;
    logic write_collision_flag_q, write_collision_flag_d;
    logic ov_q, ov_d;
    logic en_q, en_d;
    logic ckp_q, ckp_d;
    logic [3:0] mode_q, mode_d;
    logic [7:0] buf_q, buf_d;
    logic irq_q, irq_d;

    // Shift path, transmit and receive halves
    logic [7:0] tx_q, tx_d;
    logic [7:0] rx_q, rx_d;
    logic [3:0] bits_q, bits_d;

    // Master sequencer
    ssp_mstate_type ms_q, ms_d;
    logic [4:0] step_q, step_d;
    logic [5:0] div_q, div_d;
    logic act_q, act_d;
    logic sck_q, sck_d;
    logic sdo_q, sdo_d;
    // Master sample and done pulses, delayed to match the pin synchroniser
    logic [1:0] mrx_q, mrx_d;
    logic [1:0] mdone_q, mdone_d;

    // Bus handshake
    logic ack_q, ack_d;
    logic [31:0] rdata_q, rdata_d;

    // Decoded strobes and modes
    logic req, rd_acc, wr_acc;
    logic is_master, is_slave, ss_ctl;
    logic buf_wr, buf_rd, busy;
    logic [5:0] half;
    logic half_tick;

    // Two flops per pin, three on the clock pin; logic reads the second, and the third for clock edges
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sck_s1_q <= 1'b0;
            sck_s2_q <= 1'b0;
            sck_s3_q <= 1'b0;
            sdi_s1_q <= 1'b0;
            sdi_s2_q <= 1'b0;
            ss_s1_q <= 1'b1;
            ss_s2_q <= 1'b1;
        end else begin
            sck_s1_q <= sck_in;
            sck_s2_q <= sck_s1_q;
            sck_s3_q <= sck_s2_q;
            sdi_s1_q <= serial_in_pin;
            sdi_s2_q <= sdi_s1_q;
            ss_s1_q <= ss_n_in;
            ss_s2_q <= ss_s1_q;
        end
    end

    // One wait cycle per access; read data is ready when it drops
    assign req = avs_read | avs_write;
    assign avs_waitrequest = req & ~ack_q;
    assign rd_acc = avs_read & ack_q;
    assign wr_acc = avs_write & ack_q;
    assign avs_readdata = rdata_q;

    // Mode decode; unlisted codes leave the port idle
    always_comb begin
        is_master = en_q & (mode_q <= `SSP_MODE_TMR);
        is_slave = en_q & ((mode_q == `SSP_MODE_SLV_SS) |
                           (mode_q == `SSP_MODE_SLV));
        ss_ctl = mode_q == `SSP_MODE_SLV_SS;
        unique case (mode_q)
            `SSP_MODE_DIV16: half = `SSP_HALF_DIV16;
            `SSP_MODE_DIV64: half = `SSP_HALF_DIV64;
            default: half = `SSP_HALF_DIV4;
        endcase
    end

    // Buffer access strobes
    assign buf_wr = wr_acc && avs_address == `SSP_OFS_BUFFER;
    assign buf_rd = rd_acc && avs_address == `SSP_OFS_BUFFER;
    assign busy = (ms_q == SSP_M_RUN) | (bits_q != 4'h0) | (|mdone_q);

    // Bus register next values
    always_comb begin
        ack_d = req & ~ack_q;
        rdata_d = rdata_q;
        if (req && !ack_q) begin
            rdata_d = 32'h0; // Unmapped words read zero
            unique case (avs_address)
                `SSP_OFS_STATUS: begin
                    // Stop bit never set in this mode
                    rdata_d[7:0] = {smp_q, cke_q, 5'h00, bf_q};
                end
                `SSP_OFS_CTRL1: begin
                    rdata_d[7:0] = {write_collision_flag_q, ov_q, en_q, ckp_q, mode_q};
                end
                `SSP_OFS_BUFFER: rdata_d[7:0] = buf_q;
                `SSP_OFS_IRQ: rdata_d[0] = irq_q;
                default: rdata_d = 32'h0;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ack_q <= 1'b0;
            rdata_q <= 32'h0;
        end else begin
            ack_q <= ack_d;
            rdata_q <= rdata_d;
        end
    end

    // Core next-state: registers, shift path, master and slave
    always_comb begin
        logic done;
        logic samp;
        logic chg;
        logic lead;
        logic trail;
        done = 1'b0;
        samp = 1'b0;
        chg = 1'b0;
        lead = 1'b0;
        trail = 1'b0;
        smp_d = smp_q;
        cke_d = cke_q;
        bf_d = bf_q;
        write_collision_flag_d = write_collision_flag_q;
        ov_d = ov_q;
        en_d = en_q;
        ckp_d = ckp_q;
        mode_d = mode_q;
        buf_d = buf_q;
        irq_d = irq_q;
        tx_d = tx_q;
        rx_d = rx_q;
        bits_d = bits_q;
        ms_d = ms_q;
        step_d = step_q;
        div_d = div_q;
        act_d = act_q;
        half_tick = 1'b0;
        mrx_d = {mrx_q[0], 1'b0};
        mdone_d = {mdone_q[0], 1'b0};

        // Software writes first; hardware sets below win over clears
        if (wr_acc) begin
            unique case (avs_address)
                `SSP_OFS_STATUS: begin
                    smp_d = avs_writedata[`SSP_ST_SMP];
                    cke_d = avs_writedata[`SSP_ST_CKE];
                end
                `SSP_OFS_CTRL1: begin
                    write_collision_flag_d = avs_writedata[`SSP_C1_WRITE_COLLISION_FLAG];
                    ov_d = avs_writedata[`SSP_C1_OV];
                    en_d = avs_writedata[`SSP_C1_EN];
                    ckp_d = avs_writedata[`SSP_C1_CKP];
                    mode_d = avs_writedata[3:0];
                end
                `SSP_OFS_IRQ: irq_d = avs_writedata[0];
                default: ;
            endcase
        end
        if (buf_rd) begin
            bf_d = 1'b0;
        end

        // Buffer write: accepted when idle, else a collision
        if (buf_wr) begin
            if (busy) begin
                write_collision_flag_d = 1'b1;
            end else begin
                buf_d = avs_writedata[7:0];
                tx_d = avs_writedata[7:0];
                if (is_master) begin
                    ms_d = SSP_M_RUN;
                    step_d = 5'h00;
                    div_d = 6'h00;
                end
            end
        end

        // Master: half-period ticks from divider or timer
        if (ms_q == SSP_M_RUN) begin
            if (mode_q == `SSP_MODE_TMR) begin
                half_tick = timer_two_tick;
            end else if (div_q == half - 6'h01) begin
                half_tick = 1'b1;
                div_d = 6'h00;
            end else begin
                div_d = div_q + 6'h01;
            end
        end

        if (ms_q == SSP_M_RUN && half_tick) begin
            // Sample point: opposite edge, or next change edge
            if (step_q == `SSP_LAST_STEP) begin
                samp = ~cke_q & smp_q;
            end else begin
                samp = (step_q[0] != (cke_q ^ smp_q)) &&
                       !(step_q == 5'h00 && !cke_q);
                chg = (step_q[0] == cke_q) && step_q != 5'h00;
                act_d = ~step_q[0];
            end
            mrx_d[0] = samp;
            if (chg) begin
                tx_d = {tx_q[6:0], 1'b0};
            end
            if (step_q == `SSP_LAST_STEP) begin
                mdone_d[0] = 1'b1;
                act_d = 1'b0;
                ms_d = SSP_M_IDLE;
            end else begin
                step_d = step_q + 5'h01;
            end
        end

        // Pin bit seen at the sample tick leaves the synchroniser two later
        if (mrx_q[1]) begin
            rx_d = {rx_q[6:0], sdi_s2_q};
        end
        if (mdone_q[1]) begin
            done = 1'b1;
        end

        // Slave: edges of the synchronised clock pin
        if (is_slave && (!ss_ctl || !ss_s2_q)) begin
            lead = (sck_s2_q != sck_s3_q) && (sck_s2_q != ckp_q);
            trail = (sck_s2_q != sck_s3_q) && (sck_s2_q == ckp_q);
            if (cke_q ? lead : trail) begin
                rx_d = {rx_q[6:0], sdi_s2_q};
                bits_d = bits_q + 4'h1;
                if (bits_q == 4'h7) begin
                    done = 1'b1;
                    bits_d = 4'h0;
                end
            end
            // First leading edge keeps the preloaded top bit
            if (cke_q ? trail : (lead && bits_q != 4'h0)) begin
                tx_d = {tx_q[6:0], 1'b0};
            end
        end

        // Completed byte into the receive buffer
        if (done) begin
            if (is_slave && bf_q && !buf_rd) begin
                ov_d = 1'b1;
            end else begin
                buf_d = rx_d;
                bf_d = 1'b1;
            end
            irq_d = 1'b1;
        end

        // Port reset: select high in mode 4, or port disabled
        if ((is_slave && ss_ctl && ss_s2_q) || !en_q) begin
            bits_d = 4'h0;
        end
        if (!is_master) begin
            ms_d = SSP_M_IDLE;
            act_d = 1'b0;
            step_d = 5'h00;
            div_d = 6'h00;
            mrx_d = 2'h0;
            mdone_d = 2'h0;
        end
    end

    // Pin drive levels; the clock rests at the polarity level
    always_comb begin
        sck_d = ckp_q ^ act_d;
        sdo_d = tx_d[7];
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            smp_q <= 1'(`SSP_STATUS_RST >> `SSP_ST_SMP);
            cke_q <= 1'b0;
            bf_q <= 1'b0;
            write_collision_flag_q <= 1'b0;
            ov_q <= 1'b0;
            en_q <= 1'b0;
            ckp_q <= 1'b0;
            mode_q <= 4'(`SSP_CTRL1_RST);
            buf_q <= 8'h00;
            irq_q <= 1'b0;
            tx_q <= 8'h00;
            rx_q <= 8'h00;
            bits_q <= 4'h0;
            ms_q <= SSP_M_IDLE;
            step_q <= 5'h00;
            div_q <= 6'h00;
            act_q <= 1'b0;
            sck_q <= 1'b0;
            sdo_q <= 1'b0;
            mrx_q <= 2'h0;
            mdone_q <= 2'h0;
        end else begin
            smp_q <= smp_d;
            cke_q <= cke_d;
            bf_q <= bf_d;
            write_collision_flag_q <= write_collision_flag_d;
            ov_q <= ov_d;
            en_q <= en_d;
            ckp_q <= ckp_d;
            mode_q <= mode_d;
            buf_q <= buf_d;
            irq_q <= irq_d;
            tx_q <= tx_d;
            rx_q <= rx_d;
            bits_q <= bits_d;
            ms_q <= ms_d;
            step_q <= step_d;
            div_q <= div_d;
            act_q <= act_d;
            sck_q <= sck_d;
            sdo_q <= sdo_d;
            mrx_q <= mrx_d;
            mdone_q <= mdone_d;
        end
    end

    // Pin ownership and enables
    assign pins_to_port = en_q;
    assign sck_out = sck_q;
    assign sck_oe = is_master;
    assign serial_out_pin = sdo_q;
    // Floats two clocks after select goes high in mode 4, even mid-byte
    assign serial_out_oe = is_master |
        (is_slave & (~ss_ctl | ~ss_s2_q));
    assign transfer_done_irq_flag = irq_q;

endmodule // ssp_spi
`default_nettype wire

// file: testbench/sspsm_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "ssp_defines.svh"

// Port-level checks; shadows the low six control bits from bus writes
module sspsm_chk #(
    parameter int ADDR_W = 5
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic sck_out,
    input wire logic sck_oe,
    input wire logic serial_out_oe,
    input wire logic ss_n_in,
    input wire logic pins_to_port,
    input wire logic transfer_done_irq_flag
);
    logic [5:0] ctl_q; // Enable, polarity and mode as written
    logic [1:0] age_q; // Cycles since last control write, saturating
    logic busy_q; // Master byte in flight
    logic acc; // Write accepted this cycle
    logic en; // Port on and settled
    logic mst; // Settled master mode
    assign acc = avs_write && !avs_waitrequest;
    assign en = ctl_q[5] && age_q == 2'h3;
    assign mst = en && ctl_q[3:2] == 2'h0;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    // Shadow state; the age count keeps checks off reconfiguration
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ctl_q <= 6'h00;
            age_q <= 2'h0;
            busy_q <= 1'b0;
        end else if (acc && avs_address == `SSP_OFS_CTRL1) begin
            ctl_q <= avs_writedata[5:0];
            age_q <= 2'h0;
            busy_q <= 1'b0;
        end else begin
            if (age_q != 2'h3) age_q <= age_q + 2'h1;
            if ($rose(transfer_done_irq_flag)) busy_q <= 1'b0;
            else if (acc && avs_address == `SSP_OFS_BUFFER && mst) busy_q <= 1'b1;
        end
    end

    chk_wait_first: assert property (
        $rose(avs_read || avs_write) |-> avs_waitrequest) else $error("no wait");
    chk_one_wait: assert property (
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("wait too long");
    chk_read_width: assert property (
        avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
        else $error("upper read bits set");
    chk_unmapped_zero: assert property (
        avs_read && !avs_waitrequest && avs_address > `SSP_OFS_IRQ
        |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
    chk_pins_follow: assert property (
        age_q == 2'h3 |-> pins_to_port == ctl_q[5]) else $error("pin owner");
    chk_sck_dir: assert property (
        age_q == 2'h3 |-> sck_oe == (ctl_q[5] && ctl_q[3:2] == 2'h0))
        else $error("clock direction");
    chk_sck_idle: assert property (
        mst && !busy_q |-> sck_out == ctl_q[4]) else $error("clock not idle");
    chk_out_float: assert property (
        (en && ctl_q[3:0] == 4'h4 && ss_n_in)[*5] |-> !serial_out_oe)
        else $error("data out driven while deselected");
    chk_idle_codes: assert property (
        en && ctl_q[3:0] > 4'h5 |-> !serial_out_oe && !sck_oe)
        else $error("reserved mode drives pins");
    chk_irq_hold: assert property (
        $fell(transfer_done_irq_flag) |->
        $past(acc && avs_address == `SSP_OFS_IRQ && !avs_writedata[0]))
        else $error("done flag dropped");
endmodule // sspsm_chk

bind ssp_spi sspsm_chk #(.ADDR_W(ADDR_W)) u_chk (
    .ref_clk(ref_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .sck_out(sck_out), .sck_oe(sck_oe),
    .serial_out_oe(serial_out_oe), .ss_n_in(ss_n_in),
    .pins_to_port(pins_to_port),
    .transfer_done_irq_flag(transfer_done_irq_flag));

`default_nettype wire

// file: testbench/sspsm_peer.sv
`timescale 1ns/1ps
`default_nettype none

// Far-end slave: changes on the port's change edge, samples on the other
module sspsm_peer (
    input wire logic sclk,
    input wire logic from_port,
    output logic to_port,
    input wire logic idle_high,
    input wire logic late_edge,
    input wire logic load,
    input wire logic [7:0] tx_byte,
    output logic [7:0] rx_byte
);
    logic [7:0] sr; // Outgoing bits, MSB on the line
    logic primed; // Leading-edge mode: first bit shown yet
    // Until primed the line shows the inverse, never a stale bit
    assign to_port = (primed || late_edge) ? sr[7] : ~sr[7];
    initial begin
        sr = 8'h00;
        primed = 1'b0;
        rx_byte = 8'h00;
    end
    // New byte for the next frame
    always @(posedge load) begin
        sr = tx_byte;
        primed = 1'b0;
    end
    // Change edge is falling when polarity and edge select differ
    always @(sclk) begin
        if (!sclk == (idle_high ^ late_edge)) begin
            if (primed || late_edge) sr = {sr[6:0], ~sr[0]};
            primed = 1'b1;
        end else begin
            rx_byte = {rx_byte[6:0], from_port};
        end
    end
endmodule // sspsm_peer

`default_nettype wire

// file: testbench/sync_serial_port_spi_mode_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "ssp_defines.svh"

module sync_serial_port_spi_mode_tb;
    localparam logic [4:0] A_ST = `SSP_OFS_STATUS;
    localparam logic [4:0] A_C1 = `SSP_OFS_CTRL1;
    localparam logic [4:0] A_BF = `SSP_OFS_BUFFER;
    localparam logic [4:0] A_IQ = `SSP_OFS_IRQ;
    // Control, status, byte sent, byte from peer, half period
    typedef struct packed {
        logic [7:0] ctl, st, tx, rx, half;
    } sspsm_row_type;
    sspsm_row_type rows [4] = '{'{8'h20, 8'h40, 8'ha5, 8'h3c, 8'h02},
        '{8'h31, 8'h80, 8'h5e, 8'hc7, 8'h08},
        '{8'h22, 8'h00, 8'h81, 8'h7e, 8'h20},
        '{8'h33, 8'hc0, 8'h0f, 8'hf0, 8'h03}};
    logic ref_clk, rst, avs_read, avs_write, timer_two_tick, ss_n_in;
    logic [4:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic avs_waitrequest, sck_out, sck_oe, serial_out_pin, serial_out_oe;
    logic pins_to_port, transfer_done_irq_flag, miso, s_sck, s_din, slv;
    logic p_load, sck_prev;
    logic [7:0] p_tx, p_rx, got;
    logic [1:0] tk;
    int fails, n_tests, gap, half_seen;
    logic rows_hi, rows_late;
    wire sck_in, serial_in_pin;
    // Pin levels: whoever drives wins
    assign sck_in = sck_oe ? sck_out : s_sck;
    assign serial_in_pin = slv ? s_din : miso;

    ssp_spi dut (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .timer_two_tick(timer_two_tick),
        .sck_in(sck_in), .sck_out(sck_out), .sck_oe(sck_oe),
        .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin),
        .serial_out_oe(serial_out_oe), .ss_n_in(ss_n_in),
        .pins_to_port(pins_to_port),
        .transfer_done_irq_flag(transfer_done_irq_flag));
    sspsm_peer peer (.sclk(sck_out), .from_port(serial_out_pin),
        .to_port(miso), .idle_high(rows_hi), .late_edge(rows_late),
        .load(p_load), .tx_byte(p_tx), .rx_byte(p_rx));

    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    // Timer two ticks every third clock
    always @(posedge ref_clk) begin
        tk <= (tk == 2'h2) ? 2'h0 : tk + 2'h1;
        timer_two_tick <= (tk == 2'h2);
    end
    // Clocks between serial clock changes
    always @(posedge ref_clk) begin
        if (sck_out !== sck_prev) begin
            half_seen <= gap;
            gap <= 1;
        end else gap <= gap + 1;
        sck_prev <= sck_out;
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // One bus cycle, held until waitrequest is seen low
    task automatic bus(input logic [4:0] a, input logic w, input logic [7:0] d);
        logic ws;
        @(posedge ref_clk);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= {24'h0, d};
        // Settled values, as they stand at the coming rising edge
        forever begin
            @(negedge ref_clk);
            ws = avs_waitrequest;
            q = avs_readdata;
            @(posedge ref_clk);
            if (ws === 1'b0) break;
        end
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, input logic [7:0] e);
        bus(a, 1'b0, 8'h00);
        chk(q, {24'h0, e});
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        bus(a, 1'b1, d);
    endtask
    // Slave bits, idle-low clock, data set before the rising edge
    task automatic sbits(input logic [7:0] b, input int n);
        for (int i = 7; i > 7 - n; i--) begin
            s_din <= b[i];
            repeat (4) @(posedge ref_clk);
            s_sck <= 1'b1;
            repeat (4) @(posedge ref_clk);
            got = {got[6:0], serial_out_pin};
            s_sck <= 1'b0;
        end
    endtask
    task automatic wait_done;
        for (int i = 0; i < 3000 && transfer_done_irq_flag !== 1'b1; i++)
            @(posedge ref_clk);
        chk(transfer_done_irq_flag, 1'b1);
    endtask
    task end_sim;
        $display("comparisons=%0d mismatches=%0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // Watchdog, well past the expected run
    initial begin
        #200000;
        fails++;
        end_sim();
    end

    initial begin
        {rst, tk, sck_prev, gap, half_seen, fails, n_tests} = '0;
        rst = 1'b1;
        {avs_read, avs_write, avs_address, avs_writedata, q} = '0;
        {timer_two_tick, s_sck, s_din, slv, p_load, p_tx, got} = '0;
        {rows_hi, rows_late} = 2'b00;
        ss_n_in = 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        rd(A_ST, 8'h00);
        rd(A_C1, 8'h00);
        wr(A_ST, 8'hff);
        rd(A_ST, 8'hc0);
        wr(5'h10, 8'haa);
        rd(5'h10, 8'h00);
        wr(A_IQ, 8'h01);
        rd(A_IQ, 8'h01);
        wr(A_IQ, 8'h00);
        foreach (rows[i]) begin
            wr(A_C1, 8'h00);
            wr(A_ST, rows[i].st);
            wr(A_C1, rows[i].ctl);
            rows_hi <= rows[i].ctl[4];
            rows_late <= rows[i].st[6];
            p_tx <= rows[i].rx;
            repeat (4) @(posedge ref_clk);
            p_load <= 1'b1;
            wr(A_BF, rows[i].tx);
            wr(A_BF, 8'h66);
            p_load <= 1'b0;
            wait_done();
            chk(p_rx, rows[i].tx);
            chk(half_seen, rows[i].half);
            rd(A_ST, rows[i].st | 8'h01);
            rd(A_C1, rows[i].ctl | 8'h80);
            rd(A_BF, rows[i].rx);
            rd(A_ST, rows[i].st);
            wr(A_C1, rows[i].ctl);
            wr(A_IQ, 8'h00);
        end
        // Reserved code: owned pins, no traffic
        wr(A_C1, 8'h2f);
        wr(A_BF, 8'h55);
        repeat (100) @(posedge ref_clk);
        chk(transfer_done_irq_flag, 1'b0);
        rd(A_C1, 8'h2f);
        // Slave with select control
        wr(A_C1, 8'h00);
        wr(A_ST, 8'h40);
        wr(A_C1, 8'h24);
        slv <= 1'b1;
        wr(A_BF, 8'h96);
        ss_n_in <= 1'b0;
        repeat (4) @(posedge ref_clk);
        sbits(8'h5a, 8);
        wait_done();
        chk(got, 8'h96);
        wr(A_IQ, 8'h00);
        sbits(8'hc3, 8);
        wait_done();
        rd(A_C1, 8'h64);
        rd(A_BF, 8'h5a);
        wr(A_C1, 8'h24);
        wr(A_IQ, 8'h00);
        sbits(8'hff, 3);
        ss_n_in <= 1'b1;
        repeat (8) @(posedge ref_clk);
        chk(serial_out_oe, 1'b0);
        ss_n_in <= 1'b0;
        repeat (4) @(posedge ref_clk);
        sbits(8'h81, 8);
        wait_done();
        rd(A_BF, 8'h81);
        // Slave, select ignored
        wr(A_IQ, 8'h00);
        ss_n_in <= 1'b1;
        wr(A_C1, 8'h25);
        sbits(8'h3c, 8);
        wait_done();
        rd(A_BF, 8'h3c);
        // Reset in mid-run
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        rd(A_C1, 8'h00);
        end_sim();
    end
endmodule // sync_serial_port_spi_mode_tb

`default_nettype wire
